/* rtl/lmrt_ctrl.sv */
// line mode and ring trip control: mode decode, trip latch, detect/alarm
// assumes apb master on pclk; detector and thermal pins are asynchronous
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - mode code 100 enables balanced ringing, driving the ringing input onto the line.
// - ringing input passes only while a ringing mode is effective.
// - ring trip drives loop_detect_n low and latches it low.
// - trip latch clears only when software writes a different mode code.
// - ring trip disables the ringing input path.
// - ring trip forces effective mode to forward active, whatever the code says.
// - mode code 010 is unbalanced ringing, using the same trip comparison.
// - mode code 101 is loop back, enabling the internal termination.
// - in loop back, loop_detect_n is driven low.
// - in loop back, thermal_alarm_n is driven low as a path test only.
// - mode code 110 is tip open: voice off, ring-side switch only.
// - tip open picks switch hook when detector_select is 1, ground key otherwise.
// - mode code 111 is power denial: all shut down, no loop supervision.
// - battery_select changes are ignored during power denial.
// - mode code 011 is reverse active, detector chosen as in tip open.
// - battery_select high picks high battery, low picks low, in every mode but power denial.
// - overheating drives alarm low, detect high, shuts down; restored when cool.
module lmrt_ctrl
	import lmrt_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// line-side detector and sensor pins
	input wire logic ring_trip_det,
	input wire logic switch_hook_det,
	input wire logic ground_key_det,
	input wire logic over_temp,
	input wire logic ringing_input,
	// supervision outputs
	output logic loop_detect_n,
	output logic thermal_alarm_n,
	// line drive controls
	output logic ring_drive,
	output logic ring_path_en,
	output logic unbalanced_ring_en,
	output logic loopback_term_en,
	output logic reverse_polarity_en,
	output logic voice_tx_en,
	output logic tip_switch_en,
	output logic ring_switch_en,
	output logic high_battery_sel,
	output logic shutdown
);

	// ==========================================================
	// pin synchronisers
	lmrt_pins_if #(.WIDTH(LMRT_PIN_COUNT)) pins ();

	// one process drives the whole pin vector, so it has a single driver
	always_comb begin
		pins.raw = '0;
		pins.raw[LMRT_PIN_RING_TRIP] = ring_trip_det;
		pins.raw[LMRT_PIN_SW_HOOK] = switch_hook_det;
		pins.raw[LMRT_PIN_GND_KEY] = ground_key_det;
		pins.raw[LMRT_PIN_HOT] = over_temp;
		pins.raw[LMRT_PIN_RING_IN] = ringing_input;
	end

	lmrt_sync #(.WIDTH(LMRT_PIN_COUNT)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pins(pins)
	);

	logic trip_s;
	logic hook_s;
	logic gkey_s;
	logic hot_s;
	logic ring_s;
	assign trip_s = pins.sync[LMRT_PIN_RING_TRIP];
	assign hook_s = pins.sync[LMRT_PIN_SW_HOOK];
	assign gkey_s = pins.sync[LMRT_PIN_GND_KEY];
	assign hot_s = pins.sync[LMRT_PIN_HOT];
	assign ring_s = pins.sync[LMRT_PIN_RING_IN];

	function automatic logic is_ringing(input lmrt_mode_t m);
		is_ringing = (m == LMRT_MODE_BAL_RING) || (m == LMRT_MODE_UNBAL_RING);
	endfunction

	// ==========================================================
	// apb handshake: one wait state so outputs stay registered
	typedef enum logic [1:0] {
		LMRT_APB_IDLE = 2'b01,
		LMRT_APB_ACK = 2'b10
	} lmrt_apb_e;

	lmrt_apb_e apb_q;
	logic acc_hit;
	logic wr_ctrl;
	logic addr_ok;

	assign acc_hit = psel && penable && (apb_q == LMRT_APB_IDLE);
	assign addr_ok = (paddr == LMRT_CTRL_OFS) || (paddr == LMRT_STAT_OFS);
	// the write lands on the edge where pready is seen high
	assign wr_ctrl = psel && penable && (apb_q == LMRT_APB_ACK) && pwrite
		&& (paddr == LMRT_CTRL_OFS) && pstrb[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_q <= LMRT_APB_IDLE;
		end else begin
			unique case (apb_q)
				LMRT_APB_IDLE: begin
					if (acc_hit) begin
						apb_q <= LMRT_APB_ACK;
					end
				end
				LMRT_APB_ACK: begin
					apb_q <= LMRT_APB_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// control register
	lmrt_mode_t mode_q;
	logic dsel_q;
	logic battery_select_q;
	lmrt_mode_t new_mode;
	logic mode_change;

	assign new_mode = pwdata[LMRT_CTRL_MODE_LSB +: 3];
	assign mode_change = wr_ctrl && (new_mode != mode_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= LMRT_CTRL_RST[LMRT_CTRL_MODE_LSB +: 3];
			dsel_q <= LMRT_CTRL_RST[LMRT_CTRL_DSEL_BIT];
			battery_select_q <= LMRT_CTRL_RST[LMRT_CTRL_BATTERY_SELECT_BIT];
		end else if (wr_ctrl) begin
			mode_q <= new_mode;
			dsel_q <= pwdata[LMRT_CTRL_DSEL_BIT];
			battery_select_q <= pwdata[LMRT_CTRL_BATTERY_SELECT_BIT];
		end
	end

	// ==========================================================
	// ring trip latch and effective mode
	logic trip_q;
	logic trip_set;
	lmrt_mode_t eff_q;
	lmrt_mode_t eff_d;

	// trip counts only while ringing is really on the line
	assign trip_set = trip_s && is_ringing(eff_q) && !trip_q && !hot_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_q <= 1'b0;
		end else if (trip_set) begin
			trip_q <= 1'b1;
		end else if (mode_change) begin
			trip_q <= 1'b0;
		end
	end

	// a trip in the same cycle as a mode write still wins
	always_comb begin
		eff_d = wr_ctrl ? new_mode : mode_q;
		if (trip_set || (trip_q && !mode_change)) begin
			eff_d = LMRT_MODE_FWD_ACTIVE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_q <= LMRT_MODE_STANDBY;
		end else begin
			eff_q <= eff_d;
		end
	end

	// ==========================================================
	// mode decode to line controls
	logic pd;
	logic down;
	logic hook_sel;
	assign pd = (eff_q == LMRT_MODE_PWR_DENIAL);
	assign down = pd || hot_s;
	// detector choice shared by tip open and reverse active
	assign hook_sel = dsel_q ? hook_s : gkey_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_path_en <= 1'b0;
			unbalanced_ring_en <= 1'b0;
			ring_drive <= 1'b0;
		end else begin
			ring_path_en <= is_ringing(eff_q) && !trip_set && !down;
			unbalanced_ring_en <= (eff_q == LMRT_MODE_UNBAL_RING) && !trip_set && !down;
			ring_drive <= ring_s && is_ringing(eff_q) && !trip_set && !down;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loopback_term_en <= 1'b0;
			reverse_polarity_en <= 1'b0;
			voice_tx_en <= 1'b0;
			tip_switch_en <= 1'b0;
			ring_switch_en <= 1'b0;
			shutdown <= 1'b0;
		end else begin
			loopback_term_en <= (eff_q == LMRT_MODE_LOOPBACK) && !down;
			reverse_polarity_en <= (eff_q == LMRT_MODE_REV_ACTIVE) && !down;
			voice_tx_en <= !down && (eff_q != LMRT_MODE_TIP_OPEN) && !is_ringing(eff_q)
				&& (eff_q != LMRT_MODE_STANDBY);
			tip_switch_en <= !down && (eff_q != LMRT_MODE_TIP_OPEN);
			ring_switch_en <= !down;
			shutdown <= down;
		end
	end

	// battery choice is independent of mode, frozen in power denial
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_battery_sel <= 1'b0;
		end else if (!pd) begin
			high_battery_sel <= battery_select_q;
		end
	end

	// ==========================================================
	// supervision outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_detect_n <= 1'b1;
			thermal_alarm_n <= 1'b1;
		end else begin
			if (hot_s) begin
				loop_detect_n <= 1'b1;
			end else if (pd) begin
				loop_detect_n <= 1'b1;
			end else if (trip_q || trip_set) begin
				loop_detect_n <= 1'b0;
			end else if (eff_q == LMRT_MODE_LOOPBACK) begin
				loop_detect_n <= 1'b0;
			end else if (eff_q == LMRT_MODE_TIP_OPEN || eff_q == LMRT_MODE_REV_ACTIVE) begin
				loop_detect_n <= !hook_sel;
			end else if (is_ringing(eff_q)) begin
				loop_detect_n <= 1'b1;
			end else begin
				loop_detect_n <= !hook_s;
			end
			// loop back pulls the alarm only to prove the path
			thermal_alarm_n <= !(hot_s || (eff_q == LMRT_MODE_LOOPBACK));
		end
	end

	// ==========================================================
	// read data and error answer
	logic [31:0] stat_word;
	always_comb begin
		stat_word = '0;
		stat_word[LMRT_STAT_MODE_LSB +: 3] = eff_q;
		stat_word[LMRT_STAT_TRIP_BIT] = trip_q;
		stat_word[LMRT_STAT_DET_BIT] = loop_detect_n;
		stat_word[LMRT_STAT_ALM_BIT] = thermal_alarm_n;
		stat_word[LMRT_STAT_HOT_BIT] = hot_s;
		stat_word[LMRT_STAT_HBAT_BIT] = high_battery_sel;
		stat_word[LMRT_STAT_SHDN_BIT] = shutdown;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= acc_hit;
			pslverr <= acc_hit && (!addr_ok || (pwrite && paddr == LMRT_STAT_OFS));
			if (acc_hit && !pwrite && paddr == LMRT_CTRL_OFS) begin
				prdata <= {27'h0, battery_select_q, dsel_q, mode_q};
			end else if (acc_hit && !pwrite && paddr == LMRT_STAT_OFS) begin
				prdata <= stat_word;
			end else begin
				prdata <= '0;
			end
		end
	end

endmodule
`default_nettype wire

/* rtl/lmrt_pins_if.sv */
// line mode and ring trip control: raw and synchronised detector pins
// assumes one clock domain on the synchronised side
`timescale 1ns/1ps
`default_nettype none
interface lmrt_pins_if #(parameter int WIDTH = 5);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] sync;
	modport sampler (input raw, output sync);
	modport user (output raw, input sync);
endinterface
`default_nettype wire

/* rtl/lmrt_pkg.sv */
// line mode and ring trip control: shared constants
// assumes a 32-bit apb slave with word-aligned registers
package lmrt_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] LMRT_CTRL_OFS = 8'h00;
	localparam logic [7:0] LMRT_STAT_OFS = 8'h04;

	// ==========================================================
	// control field positions
	localparam int LMRT_CTRL_MODE_LSB = 0;
	localparam int LMRT_CTRL_DSEL_BIT = 3;
	localparam int LMRT_CTRL_BATTERY_SELECT_BIT = 4;

	// ==========================================================
	// status field positions
	localparam int LMRT_STAT_MODE_LSB = 0;
	localparam int LMRT_STAT_TRIP_BIT = 3;
	localparam int LMRT_STAT_DET_BIT = 4;
	localparam int LMRT_STAT_ALM_BIT = 5;
	localparam int LMRT_STAT_HOT_BIT = 6;
	localparam int LMRT_STAT_HBAT_BIT = 7;
	localparam int LMRT_STAT_SHDN_BIT = 8;

	// ==========================================================
	// operating mode codes
	typedef logic [2:0] lmrt_mode_t;
	localparam lmrt_mode_t LMRT_MODE_STANDBY = 3'h0;
	localparam lmrt_mode_t LMRT_MODE_FWD_ACTIVE = 3'h1;
	localparam lmrt_mode_t LMRT_MODE_UNBAL_RING = 3'h2;
	localparam lmrt_mode_t LMRT_MODE_REV_ACTIVE = 3'h3;
	localparam lmrt_mode_t LMRT_MODE_BAL_RING = 3'h4;
	localparam lmrt_mode_t LMRT_MODE_LOOPBACK = 3'h5;
	localparam lmrt_mode_t LMRT_MODE_TIP_OPEN = 3'h6;
	localparam lmrt_mode_t LMRT_MODE_PWR_DENIAL = 3'h7;

	// ==========================================================
	// reset values
	localparam logic [4:0] LMRT_CTRL_RST = 5'h00;

	// ==========================================================
	// synchronised pin indices
	localparam int LMRT_PIN_RING_TRIP = 0;
	localparam int LMRT_PIN_SW_HOOK = 1;
	localparam int LMRT_PIN_GND_KEY = 2;
	localparam int LMRT_PIN_HOT = 3;
	localparam int LMRT_PIN_RING_IN = 4;
	localparam int LMRT_PIN_COUNT = 5;

endpackage

/* rtl/lmrt_sync.sv */
// line mode and ring trip control: two-stage pin synchroniser bank
// assumes asynchronous pins and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module lmrt_sync #(
	parameter int WIDTH = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins in, levels out
	lmrt_pins_if.sampler pins
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds the second only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pins.raw;
			sync_q <= meta_q;
		end
	end

	assign pins.sync = sync_q;
endmodule
`default_nettype wire

/* verif/line_mode_ring_trip_control_tb.sv */
// bench for the line mode block: apb master, line model, checks
// assumes lmrt_ctrl answers one cycle after the access edge
`timescale 1ns/1ps
`default_nettype none
module line_mode_ring_trip_control_tb;
	import lmrt_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, over_temp, off_hook, gnd_key, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, rdata, rnd;
	logic [2:0] m;
	logic rd;
	logic ring_trip_det, switch_hook_det, ground_key_det, ringing_input, loop_detect_n;
	logic thermal_alarm_n, ring_drive, ring_path_en, unbalanced_ring_en, loopback_term_en;
	logic reverse_polarity_en, voice_tx_en, tip_switch_en, ring_switch_en, high_battery_sel, shutdown;
	int err_count = 0;
	int comparisons = 0;
	int seed = 45956;

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	lmrt_ctrl u_lmrt_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .ring_trip_det, .switch_hook_det, .ground_key_det,
		.over_temp, .ringing_input, .loop_detect_n, .thermal_alarm_n, .ring_drive, .ring_path_en,
		.unbalanced_ring_en, .loopback_term_en, .reverse_polarity_en, .voice_tx_en,
		.tip_switch_en, .ring_switch_en, .high_battery_sel, .shutdown);
	lmrt_line_model u_lmrt_line_model (.pclk, .off_hook, .gnd_key, .ring_path_en,
		.ring_trip_det, .switch_hook_det, .ground_key_det, .ringing_input);

	// ==========================================================
	// tasks
	task end_of_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch %s exp %0h got %0h", name, exp, got);
			err_count++;
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			end_of_test();
		end
	endtask
	task wr(input logic [2:0] c, input logic ds, input logic bs);
		apb(1'b1, LMRT_CTRL_OFS, 32'({bs, ds, c}));
		wt(4);
	endtask
	function automatic logic [4:0] exp_dec(input logic [2:0] c);
		return {c == LMRT_MODE_BAL_RING || c == LMRT_MODE_UNBAL_RING, c == LMRT_MODE_UNBAL_RING,
			c == LMRT_MODE_LOOPBACK, c == LMRT_MODE_REV_ACTIVE, c == LMRT_MODE_PWR_DENIAL};
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, over_temp, off_hook, gnd_key} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		wt(4);
		presetn <= 1'b1;
		wt(3);
		chk("standby", 32'hF, 32'({tip_switch_en, ring_switch_en, loop_detect_n, thermal_alarm_n}));
		apb(1'b0, LMRT_CTRL_OFS, 32'h0);
		chk("ctrl reset", 32'(LMRT_CTRL_RST), rdata);
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			wr(m, 1'b0, m == LMRT_MODE_BAL_RING || m == LMRT_MODE_UNBAL_RING);
			apb(1'b0, LMRT_STAT_OFS, 32'h0);
			chk("eff mode", 32'(m), 32'(rdata[2:0]));
			chk("decode", 32'(exp_dec(m)), 32'({ring_path_en, unbalanced_ring_en, loopback_term_en,
				reverse_polarity_en, shutdown}));
			if (m == LMRT_MODE_LOOPBACK) begin
				chk("loopback", 0, 32'({loop_detect_n, thermal_alarm_n}));
			end
			if (m == LMRT_MODE_TIP_OPEN) begin
				chk("tip open", 1, 32'({voice_tx_en, tip_switch_en, ring_switch_en}));
			end
			// free-running source must reach the line only in the ringing modes
			rd = 1'b0;
			repeat (8) begin
				@(posedge pclk);
				rd = rd | ring_drive;
			end
			chk("ring gate", 32'(m == LMRT_MODE_BAL_RING || m == LMRT_MODE_UNBAL_RING), 32'(rd));
		end
		wr(LMRT_MODE_PWR_DENIAL, 1'b0, 1'b1);
		chk("denial bat", 0, 32'(high_battery_sel));
		wr(LMRT_MODE_STANDBY, 1'b0, 1'b1);
		chk("bat sel", 1, 32'(high_battery_sel));
		for (int i = 0; i < 2; i++) begin
			m = i == 0 ? LMRT_MODE_BAL_RING : LMRT_MODE_UNBAL_RING;
			wr(m, 1'b0, 1'b1);
			off_hook <= 1'b1;
			wt(8);
			apb(1'b0, LMRT_STAT_OFS, 32'h0);
			chk("trip stat", 32'h9, 32'(rdata[3:0]));
			chk("trip outs", 0, 32'({loop_detect_n, ring_path_en, ring_drive}));
			off_hook <= 1'b0;
			wt(6);
			wr(m, 1'b0, 1'b1);
			chk("latch held", 0, 32'({loop_detect_n, ring_path_en}));
			wr(LMRT_MODE_FWD_ACTIVE, 1'b0, 1'b0);
			chk("latch clear", 1, 32'(loop_detect_n));
		end
		repeat (8) begin
			rnd = $random(seed);
			m = rnd[3] ? LMRT_MODE_TIP_OPEN : LMRT_MODE_REV_ACTIVE;
			off_hook <= rnd[1];
			gnd_key <= rnd[2];
			wr(m, rnd[0], rnd[4]);
			wt(4);
			chk("hook sel", 32'(!(rnd[0] ? rnd[1] : rnd[2])), 32'(loop_detect_n));
			chk("bat", 32'(rnd[4]), 32'(high_battery_sel));
		end
		apb(1'b0, 8'h08, 32'h0);
		chk("bad addr", 2, 32'({rerr, rdata != 32'h0}));
		apb(1'b1, LMRT_STAT_OFS, 32'h7);
		chk("ro write", 1, 32'(rerr));
		pstrb <= 4'hE;
		apb(1'b1, LMRT_CTRL_OFS, 32'h5);
		pstrb <= 4'hF;
		apb(1'b0, LMRT_CTRL_OFS, 32'h0);
		chk("strobe", 32'({rnd[4], rnd[0], m}), rdata);
		over_temp <= 1'b1;
		wt(6);
		chk("hot", 32'h5, 32'({shutdown, thermal_alarm_n, loop_detect_n}));
		over_temp <= 1'b0;
		wt(7);
		chk("cooled", 1, 32'({shutdown, thermal_alarm_n}));
		end_of_test();
	end
endmodule
`default_nettype wire

/* verif/lmrt_ctrl_sva.sv */
// checker for the line mode block: bus answer and supervision relations
// assumes it is bound to lmrt_ctrl and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module lmrt_ctrl_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// pins
	input wire logic over_temp,
	input wire logic ring_trip_det,
	// outputs
	input wire logic loop_detect_n,
	input wire logic thermal_alarm_n,
	input wire logic ring_drive,
	input wire logic ring_path_en,
	input wire logic loopback_term_en,
	input wire logic high_battery_sel,
	input wire logic shutdown
);
	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_pready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
	a_access_answered: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	a_ring_gated: assert property (ring_drive |-> ring_path_en) else $error("ring leak");
	a_ring_det_high: assert property (ring_path_en |-> loop_detect_n) else $error("det low");
	a_trip_stops_ring: assert property (ring_path_en && ring_trip_det && !over_temp
		|-> ##[1:5] (!ring_path_en && !loop_detect_n)) else $error("trip not taken");
	a_loopback_flags: assert property (loopback_term_en |-> !loop_detect_n && !thermal_alarm_n)
		else $error("loopback flags");
	a_hot_shutdown: assert property (over_temp [*5] |-> shutdown && !thermal_alarm_n && loop_detect_n)
		else $error("hot not handled");
	a_denial_battery: assert property (shutdown && $past(shutdown) && thermal_alarm_n
		|-> $stable(high_battery_sel)) else $error("battery moved");
	a_cool_restore: assert property ($fell(over_temp) ##1 !over_temp [*5]
		|-> thermal_alarm_n || loopback_term_en)
		else $error("alarm stuck");
endmodule
bind lmrt_ctrl lmrt_ctrl_chk u_lmrt_ctrl_chk (.pclk, .presetn, .psel, .penable, .pready,
	.over_temp, .ring_trip_det, .loop_detect_n, .thermal_alarm_n, .ring_drive, .ring_path_en,
	.loopback_term_en, .high_battery_sel, .shutdown);
`default_nettype wire

/* verif/lmrt_line_model.sv */
// line side model: hook, ground key, ring trip and a ring source
// assumes the bench sets off_hook and gnd_key
`timescale 1ns/1ps
`default_nettype none
module lmrt_line_model (
	// clock
	input wire logic pclk,
	// line state
	input wire logic off_hook,
	input wire logic gnd_key,
	input wire logic ring_path_en,
	// detector pins
	output logic ring_trip_det,
	output logic switch_hook_det,
	output logic ground_key_det,
	output logic ringing_input
);
	logic [1:0] phase_q = 2'h0;
	// source never stops, so gating must happen inside the device
	always @(posedge pclk) phase_q <= phase_q + 2'h1;
	assign ringing_input = phase_q[1];
	// peak current only while ring_path_en has the ring path on the line
	assign ring_trip_det = off_hook & ring_path_en;
	assign switch_hook_det = off_hook;
	assign ground_key_det = gnd_key;
endmodule
`default_nettype wire
